// file: hdl/signed_divide_sethi_shift_unit.sv
module signed_divide_sethi_shift_unit #(
    parameter int STEPS = divsh_pkg::DIV_STEPS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire divsh_pkg::op_t op,
    input wire logic [divsh_pkg::XLEN-1:0] upper_word,
    input wire logic [divsh_pkg::XLEN-1:0] src1_value,
    input wire logic [divsh_pkg::XLEN-1:0] src2_value,
    input wire logic imm_select,
    input wire logic [divsh_pkg::SIMM_W-1:0] signed_imm_field,
    input wire logic [divsh_pkg::HIMM_W-1:0] high_imm_field,
    input wire logic [divsh_pkg::IDX_W-1:0] dest_index,
    input wire logic after_load,
    output logic busy,
    output logic done,
    output logic rd_we,
    output logic [divsh_pkg::IDX_W-1:0] rd_index,
    output logic [divsh_pkg::XLEN-1:0] rd_value,
    output logic div_zero_trap,
    output logic [3:0] icc,
    input wire logic [divsh_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [divsh_pkg::XLEN-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [divsh_pkg::XLEN-1:0] reg_rdata,
    output logic irq
);

    // ****************************************
    // Declarations
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DIV = 2'b01,
        ST_FIN = 2'b10
    } state_t;

    state_t state;
    divsh_pkg::op_t op_q;
    logic [divsh_pkg::IDX_W-1:0] idx_q;
    logic [divsh_pkg::XLEN-1:0] dvs;
    logic [divsh_pkg::XLEN-1:0] rem;
    logic [divsh_pkg::DLEN-1:0] quo;
    logic [divsh_pkg::DLEN-1:0] dmag;
    logic neg;
    logic [divsh_pkg::CNT_W-1:0] cnt;
    logic [divsh_pkg::EV_W-1:0] status;
    logic [divsh_pkg::EV_W-1:0] mask;

    logic accept;
    logic is_div;
    logic nop_case;
    logic [divsh_pkg::XLEN-1:0] operand2;
    logic [divsh_pkg::SHAMT_W-1:0] shamt;
    logic [divsh_pkg::DLEN-1:0] dividend;
    logic [divsh_pkg::XLEN:0] trial;
    logic fits;
    logic ovf;
    logic [divsh_pkg::XLEN-1:0] quot;
    logic [divsh_pkg::EV_W-1:0] events;
    logic [divsh_pkg::XLEN-1:0] next_rdata;

    localparam logic [divsh_pkg::CNT_W-1:0] LAST_STEP =
        divsh_pkg::CNT_W'(STEPS - 1);

    // ****************************************
    // Operand selection
    // ****************************************
    always_comb
    begin
        accept = start && (state == ST_IDLE);
        is_div = (op == divsh_pkg::OP_SDIV) || (op == divsh_pkg::OP_SDIVCC);
        nop_case = (op == divsh_pkg::OP_SETHI) && after_load
            && (high_imm_field == '0)
            && (dest_index == divsh_pkg::NOP_INDEX);
        operand2 = imm_select
            ? {{(divsh_pkg::XLEN - divsh_pkg::SIMM_W)
                {signed_imm_field[divsh_pkg::SIMM_W-1]}},
               signed_imm_field}
            : src2_value;
        shamt = operand2[divsh_pkg::SHAMT_W-1:0];
        dividend = {upper_word, src1_value};
    end

    // ****************************************
    // Divider step and result
    // ****************************************
    always_comb
    begin
        trial = {rem, quo[divsh_pkg::DLEN-1]} - {1'b0, dvs};
        fits = !trial[divsh_pkg::XLEN];
        // Magnitude truncates, so rounding is toward zero
        if (neg)
        begin
            ovf = (|quo[divsh_pkg::DLEN-1:divsh_pkg::XLEN])
                || (quo[divsh_pkg::XLEN-1] && (|quo[divsh_pkg::XLEN-2:0]));
            quot = ovf ? divsh_pkg::NEG_SAT
                : -quo[divsh_pkg::XLEN-1:0];
        end
        else
        begin
            ovf = |quo[divsh_pkg::DLEN-1:divsh_pkg::XLEN];
            quot = ovf ? divsh_pkg::POS_SAT
                : quo[divsh_pkg::XLEN-1:0];
        end
    end

    // ****************************************
    // Divider sequence
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            op_q <= divsh_pkg::OP_SDIV;
            idx_q <= '0;
            dvs <= '0;
            rem <= '0;
            quo <= '0;
            dmag <= '0;
            neg <= 1'b0;
            cnt <= '0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (accept && is_div && (operand2 != '0))
                    begin
                        // Signed dividend over unsigned divisor
                        state <= ST_DIV;
                        op_q <= op;
                        idx_q <= dest_index;
                        dvs <= operand2;
                        rem <= '0;
                        neg <= dividend[divsh_pkg::DLEN-1];
                        quo <= dividend[divsh_pkg::DLEN-1]
                            ? -dividend : dividend;
                        dmag <= dividend[divsh_pkg::DLEN-1]
                            ? -dividend : dividend;
                        cnt <= '0;
                    end
                ST_DIV:
                begin
                    rem <= fits ? trial[divsh_pkg::XLEN-1:0]
                        : {rem[divsh_pkg::XLEN-2:0],
                           quo[divsh_pkg::DLEN-1]};
                    quo <= {quo[divsh_pkg::DLEN-2:0], fits};
                    cnt <= cnt + 1'b1;
                    if (cnt == LAST_STEP)
                        state <= ST_FIN;
                end
                ST_FIN:
                    state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Writeback
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            rd_we <= 1'b0;
            rd_index <= '0;
            rd_value <= '0;
            div_zero_trap <= 1'b0;
        end
        else
        begin
            busy <= (accept && is_div && (operand2 != '0))
                || (state == ST_DIV);
            done <= 1'b0;
            rd_we <= 1'b0;
            div_zero_trap <= 1'b0;
            if (state == ST_FIN)
            begin
                done <= 1'b1;
                rd_we <= 1'b1;
                rd_index <= idx_q;
                rd_value <= quot;
            end
            else if (accept)
            begin
                done <= !is_div || (operand2 == '0);
                rd_index <= dest_index;
                unique case (op)
                    divsh_pkg::OP_SDIV, divsh_pkg::OP_SDIVCC:
                        div_zero_trap <= (operand2 == '0);
                    divsh_pkg::OP_SETHI:
                    begin
                        rd_we <= !nop_case;
                        rd_value <= {high_imm_field,
                            {divsh_pkg::HIMM_LSB{1'b0}}};
                    end
                    divsh_pkg::OP_SLL:
                    begin
                        rd_we <= 1'b1;
                        rd_value <= src1_value << shamt;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Condition codes
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            icc <= divsh_pkg::ICC_RESET;
        else if ((state == ST_FIN) && (op_q == divsh_pkg::OP_SDIVCC))
        begin
            // Plain divide, set-high and shift never land here
            icc[divsh_pkg::ICC_N] <= quot[divsh_pkg::XLEN-1];
            icc[divsh_pkg::ICC_Z] <= (quot == '0);
            icc[divsh_pkg::ICC_V] <= ovf;
            icc[divsh_pkg::ICC_C] <= 1'b0;
        end
    end

    // ****************************************
    // Event status, mask and interrupt
    // ****************************************
    always_comb
    begin
        events[divsh_pkg::EV_DIV_DONE] = (state == ST_FIN);
        events[divsh_pkg::EV_OVERFLOW] = (state == ST_FIN) && ovf;
        events[divsh_pkg::EV_DIV_ZERO] = accept && is_div
            && (operand2 == '0);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            status <= divsh_pkg::EV_RESET;
            mask <= divsh_pkg::EV_RESET;
            irq <= 1'b0;
        end
        else
        begin
            // Set wins over a write-one clear in the same cycle
            if (reg_wr && (reg_addr == divsh_pkg::OFF_STATUS))
                status <= (status & ~reg_wdata[divsh_pkg::EV_W-1:0])
                    | events;
            else
                status <= status | events;
            if (reg_wr && (reg_addr == divsh_pkg::OFF_MASK))
                mask <= reg_wdata[divsh_pkg::EV_W-1:0];
            irq <= |(status & mask);
        end
    end

    // ****************************************
    // Register read
    // ****************************************
    always_comb
    begin
        next_rdata = '0;
        unique case (reg_addr)
            divsh_pkg::OFF_STATUS:
                next_rdata[divsh_pkg::EV_W-1:0] = status;
            divsh_pkg::OFF_MASK:
                next_rdata[divsh_pkg::EV_W-1:0] = mask;
            divsh_pkg::OFF_ICC:
                next_rdata[3:0] = icc;
            default:
                next_rdata = '0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            reg_rdata <= '0;
        else
            reg_rdata <= reg_rd ? next_rdata : '0;
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_sethi_value: assert property (
        accept && (op == divsh_pkg::OP_SETHI) && !nop_case |=> rd_we && done
        && (rd_value == {$past(high_imm_field), 10'h000})
        && $stable(icc))
        else $error("set-high result wrong");

    a_sethi_nop: assert property (
        accept && nop_case |=> done && !rd_we && !busy)
        else $error("set-high no-op wrote or stalled");

    a_shift_value: assert property (
        accept && (op == divsh_pkg::OP_SLL) |=> rd_we && done
        && (rd_value == ($past(src1_value) << $past(shamt))))
        else $error("shift result wrong");

    a_shift_quiet: assert property (
        accept && (op == divsh_pkg::OP_SLL) |=> !div_zero_trap
        ##1 $stable(icc))
        else $error("shift touched flags or trapped");

    a_zero_trap: assert property (
        accept && is_div && (operand2 == '0) |=> div_zero_trap && !rd_we
        && !busy && $stable(icc))
        else $error("zero divisor not trapped");

    a_div_latency: assert property (
        accept && is_div && (operand2 != '0)
        |=> busy [*8] ##58 (done && rd_we && !div_zero_trap))
        else $error("divide did not finish in time");
    a_plain_keep: assert property (
        (state == ST_FIN) && (op_q == divsh_pkg::OP_SDIV) |=> $stable(icc))
        else $error("plain divide changed flags");
    a_flag_update: assert property (
        (state == ST_FIN) && (op_q == divsh_pkg::OP_SDIVCC) |=> rd_we
        && (icc[3] == rd_value[31]) && (icc[2] == (rd_value == '0))
        && (icc[1] == $past(ovf)) && !icc[0])
        else $error("flag divide flags wrong");
    a_quot_exact: assert property (
        (state == ST_FIN) |-> (quo * {32'h0, dvs}) + {32'h0, rem} == dmag)
        else $error("quotient and remainder inconsistent");
    a_saturate: assert property (
        (state == ST_FIN) && ovf |=> rd_value == ($past(neg)
        ? 32'h80000000 : 32'hffffffff))
        else $error("overflow not saturated");

    c_div_overflow: cover property (
        (state == ST_FIN) && ovf && (op_q == divsh_pkg::OP_SDIVCC));
    c_zero_trap: cover property (div_zero_trap);
    c_sethi_nop: cover property (accept && nop_case);
    c_negative_div: cover property ((state == ST_FIN) && neg && !ovf);

endmodule

// file: hdl/divsh_pkg.sv
package divsh_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int XLEN = 32;
    localparam int DLEN = 64;
    localparam int SIMM_W = 13;
    localparam int HIMM_W = 22;
    localparam int HIMM_LSB = 10;
    localparam int SHAMT_W = 5;
    localparam int IDX_W = 5;
    localparam int CNT_W = 7;
    localparam int DIV_STEPS = 64;

    // ****************************************
    // Operations
    // ****************************************
    typedef enum logic [1:0] {
        OP_SDIV = 2'b00,
        OP_SDIVCC = 2'b01,
        OP_SETHI = 2'b10,
        OP_SLL = 2'b11
    } op_t;

    // ****************************************
    // Condition code layout
    // ****************************************
    localparam int ICC_N = 3;
    localparam int ICC_Z = 2;
    localparam int ICC_V = 1;
    localparam int ICC_C = 0;
    localparam logic [3:0] ICC_RESET = 4'h0;

    // ****************************************
    // Saturation values and no-op index
    // ****************************************
    localparam logic [XLEN-1:0] POS_SAT = 32'hffffffff;
    localparam logic [XLEN-1:0] NEG_SAT = 32'h80000000;
    localparam logic [4:0] NOP_INDEX = 5'h00;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_MASK = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_ICC = 4'h8;
    localparam int EV_W = 3;
    localparam int EV_DIV_DONE = 0;
    localparam int EV_OVERFLOW = 1;
    localparam int EV_DIV_ZERO = 2;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;

endpackage

// file: test/int_regfile_model.sv
module int_regfile_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic rd_we,
    input wire logic [divsh_pkg::IDX_W-1:0] rd_index,
    input wire logic [divsh_pkg::XLEN-1:0] rd_value
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [divsh_pkg::XLEN-1:0] regs [32];

    // ****************
    // Write port
    // ****************
    // Upper word is not kept here, it is supplied anew per divide
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 32; i++)
            begin
                regs[i] <= '0;
            end
        end
        else if (rd_we && rd_index != divsh_pkg::NOP_INDEX)
        begin
            regs[rd_index] <= rd_value;
        end
    end
endmodule

// file: test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    divsh_pkg::op_t op = divsh_pkg::OP_SLL;
    logic [31:0] upper_word = 32'h0;
    logic [31:0] src1_value = 32'h0;
    logic [31:0] src2_value = 32'h0;
    logic imm_select = 1'b0;
    logic [12:0] signed_imm_field = 13'h0;
    logic [21:0] high_imm_field = 22'h0;
    logic [4:0] dest_index = 5'h3;
    logic after_load = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic busy, done, rd_we, div_zero_trap, irq, got_we, got_trap, got_busy;
    logic [4:0] rd_index;
    logic [31:0] rd_value, reg_rdata, got_val, rdv;
    logic [3:0] icc;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    int lat;

    signed_divide_sethi_shift_unit i_signed_divide_sethi_shift_unit (
        .ref_clk, .rst, .start, .op, .upper_word, .src1_value,
        .src2_value, .imm_select, .signed_imm_field, .high_imm_field,
        .dest_index, .after_load, .busy, .done, .rd_we, .rd_index,
        .rd_value, .div_zero_trap, .icc, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .irq
    );
    int_regfile_model i_int_regfile_model (
        .ref_clk, .rst, .rd_we, .rd_index, .rd_value
    );

    // ****************
    // Clock and watchdog
    // ****************
    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            $display("[ERR] %0t run did not complete", $time);
            finish_test();
        end
    end

    // ****************
    // Compare and bus tasks
    // ****************
    task automatic check_word(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %0t word %h expected %h", $time, g, e);
        end
    endtask
    task automatic check_flag(input logic g, input logic e);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %0t flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask
    task automatic issue(input divsh_pkg::op_t o, input logic [31:0] u,
        input logic [31:0] a, input logic [31:0] b, input logic s,
        input logic [12:0] im);
        @(posedge ref_clk);
        op <= o;
        upper_word <= u;
        src1_value <= a;
        src2_value <= b;
        imm_select <= s;
        signed_imm_field <= im;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        #1;
        got_busy = busy;
        lat = 0;
        while (done !== 1'b1 && lat < 100)
        begin
            @(posedge ref_clk);
            #1;
            lat++;
        end
        got_we = rd_we;
        got_val = rd_value;
        got_trap = div_zero_trap;
    endtask

    // ****************
    // Scenarios
    // ****************
    function automatic logic [32:0] div_ref(input logic [63:0] dd,
        input logic [31:0] dv);
        logic [63:0] m;
        logic [63:0] q;
        m = dd[63] ? -dd : dd;
        q = m / {32'h0, dv};
        if (!dd[63])
            return q > 64'hffffffff ? {1'b1, divsh_pkg::POS_SAT} :
                {1'b0, q[31:0]};
        return q > 64'h80000000 ? {1'b1, divsh_pkg::NEG_SAT} :
            {1'b0, -q[31:0]};
    endfunction
    task automatic test_div(input divsh_pkg::op_t o, input logic [31:0] u,
        input logic [31:0] a, input logic [31:0] b, input logic s,
        input logic [12:0] im);
        logic [32:0] e;
        logic [3:0] icc0;
        e = div_ref({u, a}, s ? {{19{im[12]}}, im} : b);
        icc0 = icc;
        if (o == divsh_pkg::OP_SDIVCC)
            icc0 = {e[31], e[31:0] == 32'h0, e[32], 1'b0};
        issue(o, u, a, b, s, im);
        check_word(32'(lat), 32'h41);
        check_flag(got_busy, 1'b1);
        check_flag(got_we, 1'b1);
        check_word(got_val, e[31:0]);
        check_word({28'h0, icc}, {28'h0, icc0});
    endtask
    task automatic test_zero();
        logic [3:0] icc0;
        icc0 = icc;
        issue(divsh_pkg::OP_SDIVCC, 32'h0, 32'h9, 32'h0, 1'b0, 13'h0);
        check_word(32'(lat), 32'h0);
        check_flag(got_busy, 1'b0);
        check_flag(got_trap, 1'b1);
        check_flag(got_we, 1'b0);
        check_word({28'h0, icc}, {28'h0, icc0});
    endtask
    task automatic test_sll();
        logic [3:0] icc0;
        icc0 = icc;
        issue(divsh_pkg::OP_SLL, 32'h0, 32'h8000000f, 32'hffffffe4, 1'b0,
            13'h0);
        check_word(got_val, 32'h000000f0);
        issue(divsh_pkg::OP_SLL, 32'h0, 32'h8000000f, 32'h4, 1'b1, 13'h1fe3);
        check_word(got_val, 32'h00000078);
        issue(divsh_pkg::OP_SLL, 32'h0, 32'h8000000f, 32'h20, 1'b0, 13'h0);
        check_word(got_val, 32'h8000000f);
        check_flag(got_trap, 1'b0);
        check_word({28'h0, icc}, {28'h0, icc0});
    endtask
    task automatic test_sethi();
        logic [3:0] icc0;
        icc0 = icc;
        @(posedge ref_clk);
        high_imm_field <= 22'h2abcde;
        issue(divsh_pkg::OP_SETHI, 32'h0, 32'hffffffff, 32'h0, 1'b0, 13'h0);
        check_word(got_val, 32'haaf37800);
        check_word({28'h0, icc}, {28'h0, icc0});
        @(posedge ref_clk);
        high_imm_field <= 22'h0;
        dest_index <= 5'h0;
        after_load <= 1'b1;
        #1;
        check_word(i_int_regfile_model.regs[3], 32'haaf37800);
        issue(divsh_pkg::OP_SETHI, 32'h0, 32'h0, 32'h0, 1'b0, 13'h0);
        check_word(32'(lat), 32'h0);
        check_flag(got_we, 1'b0);
        @(posedge ref_clk);
        dest_index <= 5'h3;
        after_load <= 1'b0;
    endtask
    task automatic test_irq();
        reg_write(divsh_pkg::OFF_STATUS, 32'h7);
        reg_read(divsh_pkg::OFF_STATUS);
        check_word(rdv, 32'h0);
        test_div(divsh_pkg::OP_SDIVCC, 32'h2, 32'h0, 32'h1, 1'b0, 13'h0);
        reg_read(divsh_pkg::OFF_STATUS);
        check_word(rdv, 32'h3);
        check_flag(irq, 1'b0);
        reg_write(divsh_pkg::OFF_MASK, 32'h2);
        repeat (2) @(posedge ref_clk);
        #1;
        check_flag(irq, 1'b1);
        reg_write(divsh_pkg::OFF_STATUS, 32'h2);
        repeat (2) @(posedge ref_clk);
        #1;
        check_flag(irq, 1'b0);
        reg_read(divsh_pkg::OFF_MASK);
        check_word(rdv, 32'h2);
        reg_write(4'hc, 32'hffffffff);
        reg_read(4'hc);
        check_word(rdv, 32'h0);
        reg_read(divsh_pkg::OFF_ICC);
        check_word(rdv, 32'ha);
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ****************
    // Main sequence
    // ****************
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        reg_read(divsh_pkg::OFF_MASK);
        check_word(rdv, 32'h0);
        check_word({28'h0, icc}, 32'h0);
        test_div(divsh_pkg::OP_SDIV, 32'h0, 32'h64, 32'h7, 1'b0,
            13'h0);
        test_div(divsh_pkg::OP_SDIV, '1, 32'hffffff9c, 32'h7, 1'b0,
            13'h0);
        test_div(divsh_pkg::OP_SDIVCC, 32'h1, 32'h0, 32'h0, 1'b1,
            13'h1fff);
        test_div(divsh_pkg::OP_SDIVCC, 32'h2, 32'h0, 32'h1, 1'b0,
            13'h0);
        test_div(divsh_pkg::OP_SDIV, 32'hfffffffe, 32'h0, 32'h1, 1'b0,
            13'h0);
        test_div(divsh_pkg::OP_SDIVCC, 32'h0, 32'h0, 32'h5, 1'b0,
            13'h0);
        test_div(divsh_pkg::OP_SDIVCC, '1, 32'h80000000, 32'h1, 1'b0,
            13'h0);
        test_zero();
        test_sll();
        test_sethi();
        test_irq();
        finish_test();
    end
endmodule
